// >>> logic/tsq_top.v
// tsq_top - arm/trigger sequencer with six digital lines behind an apb slave
// assumes one 125 MHz clock, line and key inputs asynchronous to it are synchronised here
`timescale 1ns/1ns
`include "tsq_consts.vh"
module tsq_top
#(
  parameter STEP_CYC = `TSQ_STEP_NS / `TSQ_CLK_NS
)
(
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire [5:0]  line_i,
  output reg  [5:0]  line_o,
  output reg  [5:0]  line_oe_n,
  input  wire        trig_key,
  input  wire        fault_event,
  input  wire [6:0]  event_level,
  input  wire        meas_done,
  output reg         meas_start,
  output reg  [15:0] level_out,
  output reg  [3:0]  line_cmd
);

  localparam S_IDLE = 6'h01;
  localparam S_ARM  = 6'h02;
  localparam S_TRIG = 6'h04;
  localparam S_SRC  = 6'h08;
  localparam S_DLY  = 6'h10;
  localparam S_MEAS = 6'h20;

  ////////////////////////////////////////////////////////////////////////
  // configuration and state
  reg  [1:0]  mode_reg;
  reg         cont_reg;
  reg         slew_reg;
  reg  [1:0]  arm_src_reg;
  reg  [1:0]  trig_src_reg;
  reg  [15:0] arm_count_reg;
  reg  [15:0] trig_count_reg;
  reg  [19:0] delay_reg;
  reg  [15:0] target_reg;
  reg  [15:0] slew_step_reg;
  reg  [15:0] err_reg;
  reg         fault_reg;
  reg  [2:0]  fn_reg  [0:5];
  reg  [2:0]  act_reg [0:5];
  reg  [5:0]  state_reg;
  reg  [15:0] arm_cnt_reg;
  reg  [15:0] trig_cnt_reg;
  reg  [19:0] dly_units_reg;
  reg  [31:0] dly_sub_reg;
  reg  [15:0] mdone_cnt_reg;
  reg         bus_trg_reg;
  reg         init_reg;
  reg         abort_reg;
  reg         clr_fault_reg;

  wire [5:0]  line_lvl;
  wire [5:0]  line_fall;
  wire        key_press;

  ////////////////////////////////////////////////////////////////////////
  // event synchronisers, one per line plus the front key
  // sync to pclk
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi = gi + 1)
    begin : g_line_sync
      tsq_edge_sync #(.FALL(1)) u_sync
      (
        .pclk       (pclk),
        .presetn    (presetn),
        .din        (line_i[gi]),
        .level      (line_lvl[gi]),
        .edge_pulse (line_fall[gi])
      );
    end
  endgenerate

  tsq_edge_sync #(.FALL(0)) u_key_sync
  (
    .pclk       (pclk),
    .presetn    (presetn),
    .din        (trig_key),
    .level      (),
    .edge_pulse (key_press)
  );

  ////////////////////////////////////////////////////////////////////////
  // permission check of a line configuration against the operating mode
  function cfg_ok;
    input [1:0] md;
    input [2:0] idx;
    input [2:0] fn;
    input [2:0] act;
    reg         ev_line;
    begin
      ev_line = (idx == 3'h1) | (idx >= 3'h3);
      case (fn)
        `TSQ_FN_MIN, `TSQ_FN_MOUTH, `TSQ_FN_MOUTL: cfg_ok = 1'b1;
        // trigger in on line1, fault on line3
        `TSQ_FN_TRIGIN: cfg_ok = (idx == 3'h0);
        `TSQ_FN_FAULT:  cfg_ok = (idx == 3'h2);
        // measure done only line2 in supply mode
        `TSQ_FN_MDONE:  cfg_ok = (idx == 3'h1) & (md == `TSQ_MODE_SUPPLY);
        `TSQ_FN_DOUT:   cfg_ok = ev_line & (((md == `TSQ_MODE_BATTEST) & (act <= `TSQ_ACT_END)) |
                                 ((md == `TSQ_MODE_BATSIM) & (act != `TSQ_ACT_REGCHG) & (act != `TSQ_ACT_END)
                                  & (act <= `TSQ_ACT_EMPTY)));
        `TSQ_FN_DIN:    cfg_ok = ev_line & (((md == `TSQ_MODE_BATTEST) & (act <= `TSQ_ACT_SSTOP)) |
                                 ((md == `TSQ_MODE_BATSIM) & (act <= `TSQ_ACT_OFF)));
        default:        cfg_ok = 1'b0;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // apb decode; two-cycle access so read data comes from a flop
  wire        acc      = psel & penable & ~pready;
  wire        wr_fire  = psel & penable & pready & pwrite;
  wire        line_hit = (paddr >= `TSQ_OFS_LINE0) & (paddr <= `TSQ_OFS_LINE_LAST) & (paddr[1:0] == 2'h0);
  wire [7:0]  lofs     = paddr - `TSQ_OFS_LINE0;
  wire [2:0]  lidx     = lofs[4:2];
  wire        reg_hit  = (paddr <= `TSQ_OFS_LEVEL) & (paddr[1:0] == 2'h0);
  wire        lin_ok   = line_hit & (fn_reg[lidx] == `TSQ_FN_MIN);
  wire        cfg_good = cfg_ok(mode_reg, lidx, pwdata[6:4], pwdata[10:8]);
  reg  [31:0] rd_data;

  always @*
  begin
    rd_data = 32'h0000_0000;
    case (paddr)
      `TSQ_OFS_CTRL:   rd_data = {28'h0, slew_reg, cont_reg, mode_reg};
      `TSQ_OFS_ARM:    rd_data = {arm_count_reg, 14'h0, arm_src_reg};
      `TSQ_OFS_TRIG:   rd_data = {trig_count_reg, 14'h0, trig_src_reg};
      `TSQ_OFS_DELAY:  rd_data = {12'h0, delay_reg};
      `TSQ_OFS_STATUS: rd_data = {trig_cnt_reg[7:0], arm_cnt_reg[7:0], 8'h0, 1'b0, fault_reg, state_reg};
      `TSQ_OFS_ERR:    rd_data = {16'h0, err_reg};
      `TSQ_OFS_LEVEL:  rd_data = {slew_step_reg, target_reg};
      default:         rd_data = 32'h0000_0000;
    endcase
    // level only for a manual input line
    if (line_hit)
      rd_data = lin_ok ? {31'h0, line_lvl[lidx]} : 32'h0000_0000;
  end

  // bus answer and error capture
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else
    begin
      pready  <= acc;
      pslverr <= acc & ~(reg_hit | line_hit | (!pwrite & line_hit & lin_ok)) |
                 (acc & line_hit & (pwrite ? ~cfg_good : ~lin_ok));
      prdata  <= (acc & !pwrite) ? rd_data : 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register writes; command bits are single-cycle strobes
  integer k;
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode_reg       <= `TSQ_MODE_SUPPLY;
      cont_reg       <= 1'b0;
      slew_reg       <= 1'b0;
      arm_src_reg    <= `TSQ_SRC_IMM;
      trig_src_reg   <= `TSQ_SRC_IMM;
      arm_count_reg  <= `TSQ_RST_COUNT;
      trig_count_reg <= `TSQ_RST_COUNT;
      delay_reg      <= `TSQ_RST_DELAY;
      target_reg     <= 16'h0000;
      slew_step_reg  <= 16'h0001;
      err_reg        <= 16'h0000;
      init_reg       <= 1'b0;
      bus_trg_reg    <= 1'b0;
      abort_reg      <= 1'b0;
      clr_fault_reg  <= 1'b0;
      for (k = 0; k < 6; k = k + 1)
      begin
        fn_reg[k]  <= `TSQ_FN_MIN;
        act_reg[k] <= 3'h0;
      end
    end
    else
    begin
      init_reg      <= 1'b0;
      bus_trg_reg   <= 1'b0;
      abort_reg     <= 1'b0;
      clr_fault_reg <= 1'b0;
      // failed line read leaves error 508
      if (acc & !pwrite & line_hit & ~lin_ok)
        err_reg <= `TSQ_ERR_NOT_INPUT;
      if (wr_fire)
      begin
        case (paddr)
          `TSQ_OFS_CTRL:
          begin
            mode_reg <= (pwdata[1:0] == 2'h3) ? mode_reg : pwdata[1:0];
            cont_reg <= pwdata[`TSQ_CTRL_CONT_BIT];
            slew_reg <= pwdata[`TSQ_CTRL_SLEW_BIT];
          end
          `TSQ_OFS_CMD:
          begin
            init_reg      <= pwdata[`TSQ_CMD_INIT_BIT];
            bus_trg_reg   <= pwdata[`TSQ_CMD_BUS_BIT];
            abort_reg     <= pwdata[`TSQ_CMD_ABORT_BIT];
            clr_fault_reg <= pwdata[`TSQ_CMD_CLRF_BIT];
          end
          `TSQ_OFS_ARM:
          begin
            arm_src_reg   <= pwdata[1:0];
            arm_count_reg <= (pwdata[31:16] == 16'h0) ? `TSQ_RST_COUNT : pwdata[31:16];
          end
          `TSQ_OFS_TRIG:
          begin
            // bus source refused in trigger layer
            if (pwdata[1:0] != `TSQ_SRC_BUS)
              trig_src_reg <= pwdata[1:0];
            trig_count_reg <= (pwdata[31:16] == 16'h0) ? `TSQ_RST_COUNT : pwdata[31:16];
          end
          // delay clipped to its top step
          `TSQ_OFS_DELAY: delay_reg <= (pwdata[19:0] > `TSQ_MAX_DELAY) ? `TSQ_MAX_DELAY : pwdata[19:0];
          `TSQ_OFS_ERR:   err_reg <= 16'h0000;
          `TSQ_OFS_LEVEL:
          begin
            target_reg    <= pwdata[15:0];
            slew_step_reg <= (pwdata[31:16] == 16'h0) ? 16'h0001 : pwdata[31:16];
          end
          default:
          begin
            if (line_hit & cfg_good)
            begin
              fn_reg[lidx]  <= pwdata[6:4];
              act_reg[lidx] <= pwdata[10:8];
            end
            else if (line_hit)
              err_reg <= `TSQ_ERR_BAD_CFG;
          end
        endcase
      end
      // external source forces line1 to trigger in
      if ((arm_src_reg == `TSQ_SRC_EXT) | (trig_src_reg == `TSQ_SRC_EXT))
        fn_reg[0] <= `TSQ_FN_TRIGIN;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sequencer
  // trigger line fires on its falling edge
  wire ext_evt  = line_fall[0] & (fn_reg[0] == `TSQ_FN_TRIGIN);
  wire arm_evt  = (arm_src_reg == `TSQ_SRC_IMM) | ((arm_src_reg == `TSQ_SRC_BUS) & bus_trg_reg) |
                  ((arm_src_reg == `TSQ_SRC_EXT) & ext_evt) | ((arm_src_reg == `TSQ_SRC_MAN) & key_press);
  wire trig_evt = (trig_src_reg == `TSQ_SRC_IMM) | ((trig_src_reg == `TSQ_SRC_EXT) & ext_evt) |
                  ((trig_src_reg == `TSQ_SRC_MAN) & key_press);
  wire [15:0] trig_cnt_inc = trig_cnt_reg + 16'h0001;
  wire [15:0] arm_cnt_inc  = arm_cnt_reg + 16'h0001;
  wire [15:0] up_sum       = level_out + slew_step_reg;
  wire [15:0] dn_diff      = level_out - slew_step_reg;
  wire        step_done    = (dly_sub_reg == STEP_CYC - 1);

  // events outside their wait state simply fall through unused
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg     <= S_IDLE;
      arm_cnt_reg   <= 16'h0000;
      trig_cnt_reg  <= 16'h0000;
      dly_units_reg <= 20'h00000;
      dly_sub_reg   <= 32'h0000_0000;
      meas_start    <= 1'b0;
      level_out     <= 16'h0000;
      mdone_cnt_reg <= 16'h0000;
    end
    else
    begin
      meas_start <= 1'b0;
      if (mdone_cnt_reg != 16'h0000)
        mdone_cnt_reg <= mdone_cnt_reg - 16'h0001;
      if (abort_reg)
        state_reg <= S_IDLE;
      else
      case (state_reg)
        S_IDLE:
          if (init_reg)
          begin
            arm_cnt_reg <= 16'h0000;
            state_reg   <= S_ARM;
          end
        S_ARM:
          if (arm_evt)
          begin
            trig_cnt_reg <= 16'h0000;
            state_reg    <= S_TRIG;
          end
        S_TRIG:
          if (trig_evt)
            state_reg <= S_SRC;
        S_SRC:
          if (level_out == target_reg)
          begin
            dly_units_reg <= delay_reg;
            dly_sub_reg   <= 32'h0000_0000;
            state_reg     <= S_DLY;
          end
          else if (!slew_reg)
            level_out <= target_reg;
          else if (level_out < target_reg)
            level_out <= ((target_reg - level_out) <= slew_step_reg) ? target_reg : up_sum;
          else
            level_out <= ((level_out - target_reg) <= slew_step_reg) ? target_reg : dn_diff;
        S_DLY:
          if (dly_units_reg == 20'h00000)
          begin
            meas_start <= 1'b1;
            state_reg  <= S_MEAS;
          end
          else if (step_done)
          begin
            dly_sub_reg   <= 32'h0000_0000;
            dly_units_reg <= dly_units_reg - 20'h00001;
          end
          else
            dly_sub_reg <= dly_sub_reg + 32'h0000_0001;
        S_MEAS:
          if (meas_done)
          begin
            mdone_cnt_reg <= `TSQ_MDONE_CYC;
            trig_cnt_reg  <= trig_cnt_inc;
            if (trig_cnt_inc < trig_count_reg)
              state_reg <= S_TRIG;
            else if (arm_cnt_inc < arm_count_reg)
            begin
              arm_cnt_reg <= arm_cnt_inc;
              state_reg   <= S_ARM;
            end
            else if (cont_reg)
            begin
              arm_cnt_reg <= 16'h0000;
              state_reg   <= S_ARM;
            end
            else
              state_reg <= S_IDLE;
          end
        default: state_reg <= S_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // fault latch: a new fault beats a clear in the same cycle
  // held until cleared
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      fault_reg <= 1'b0;
    else if (fault_event)
      fault_reg <= 1'b1;
    else if (clr_fault_reg)
      fault_reg <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // line drivers and command inputs, registered so pins never glitch
  reg [5:0] lo_next;
  reg [5:0] oe_next;
  reg [3:0] cmd_next;
  integer   j;
  always @*
  begin
    lo_next  = 6'h3f;
    oe_next  = 6'h3f;
    cmd_next = 4'h0;
    for (j = 0; j < 6; j = j + 1)
    begin
      case (fn_reg[j])
        `TSQ_FN_MOUTH: oe_next[j] = 1'b0;
        `TSQ_FN_MOUTL:
        begin
          oe_next[j] = 1'b0;
          lo_next[j] = 1'b0;
        end
        // idle high, low while the pulse counter runs
        `TSQ_FN_MDONE:
        begin
          oe_next[j] = 1'b0;
          lo_next[j] = (mdone_cnt_reg == 16'h0000);
        end
        `TSQ_FN_FAULT:
        begin
          oe_next[j] = 1'b0;
          lo_next[j] = ~fault_reg;
        end
        `TSQ_FN_DOUT:
        begin
          oe_next[j] = 1'b0;
          lo_next[j] = event_level[act_reg[j]];
        end
        `TSQ_FN_DIN:
          if (line_fall[j])
            cmd_next[act_reg[j][1:0]] = 1'b1;
        default: oe_next[j] = 1'b1;
      endcase
    end
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      line_o    <= 6'h3f;
      line_oe_n <= 6'h3f;
      line_cmd  <= 4'h0;
    end
    else
    begin
      line_o    <= lo_next;
      line_oe_n <= oe_next;
      line_cmd  <= cmd_next;
    end
  end

endmodule

// >>> common/tsq_consts.vh
// tsq_consts.vh - offsets, fields, reset values and timing counts of the trigger sequencer
// assumes a 125 MHz pclk and a 32-bit apb register bus
`ifndef TSQ_CONSTS_VH
`define TSQ_CONSTS_VH

// register byte offsets
`define TSQ_OFS_CTRL      8'h00
`define TSQ_OFS_CMD       8'h04
`define TSQ_OFS_ARM       8'h08
`define TSQ_OFS_TRIG      8'h0c
`define TSQ_OFS_DELAY     8'h10
`define TSQ_OFS_STATUS    8'h14
`define TSQ_OFS_ERR       8'h18
`define TSQ_OFS_LEVEL     8'h1c
`define TSQ_OFS_LINE0     8'h20
`define TSQ_OFS_LINE_LAST 8'h34

// ctrl fields
`define TSQ_MODE_SUPPLY   2'h0
`define TSQ_MODE_BATTEST  2'h1
`define TSQ_MODE_BATSIM   2'h2
`define TSQ_CTRL_CONT_BIT 2
`define TSQ_CTRL_SLEW_BIT 3

// cmd bits
`define TSQ_CMD_INIT_BIT  0
`define TSQ_CMD_BUS_BIT   1
`define TSQ_CMD_ABORT_BIT 2
`define TSQ_CMD_CLRF_BIT  3

// event sources
`define TSQ_SRC_IMM       2'h0
`define TSQ_SRC_BUS       2'h1
`define TSQ_SRC_EXT       2'h2
`define TSQ_SRC_MAN       2'h3

// line functions
`define TSQ_FN_MIN        3'h0
`define TSQ_FN_MOUTH      3'h1
`define TSQ_FN_MOUTL      3'h2
`define TSQ_FN_TRIGIN     3'h3
`define TSQ_FN_MDONE      3'h4
`define TSQ_FN_FAULT      3'h5
`define TSQ_FN_DOUT       3'h6
`define TSQ_FN_DIN        3'h7

// line actions: outputs
`define TSQ_ACT_POLARITY  3'h0
`define TSQ_ACT_OVERV     3'h1
`define TSQ_ACT_UNDERV    3'h2
`define TSQ_ACT_REGCHG    3'h3
`define TSQ_ACT_END       3'h4
`define TSQ_ACT_FULL      3'h5
`define TSQ_ACT_EMPTY     3'h6
// line actions: inputs
`define TSQ_ACT_ON        3'h0
`define TSQ_ACT_OFF       3'h1
`define TSQ_ACT_SSTART    3'h2
`define TSQ_ACT_SSTOP     3'h3

// error codes
`define TSQ_ERR_NOT_INPUT 16'h01fc
`define TSQ_ERR_BAD_CFG   16'h00dc

// reset values and delay limit
`define TSQ_RST_COUNT     16'h0001
`define TSQ_RST_DELAY     20'h00000
`define TSQ_MAX_DELAY     20'hf423f

// timing: clock period, settle step, measurement-done pulse
`define TSQ_CLK_NS        8
`define TSQ_STEP_NS       100000
`define TSQ_MDONE_NS      20000
// 2500 cycles of 8 ns, sized to the pulse counter
`define TSQ_MDONE_CYC     16'h09c4

`endif

// >>> logic/tsq_edge_sync.v
// tsq_edge_sync - two-flop synchroniser with a single-cycle edge pulse
// assumes one clock; FALL selects falling (1) or rising (0) edge
`timescale 1ns/1ns
module tsq_edge_sync
#(
  parameter FALL = 1
)
(
  input  wire pclk,
  input  wire presetn,
  input  wire din,
  output wire level,
  output reg  edge_pulse
);

  reg meta_reg;
  reg sync_reg;
  reg last_reg;

  assign level = sync_reg;

  // idle-high reset so a quiet line raises no edge at release
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_reg   <= 1'b1;
      sync_reg   <= 1'b1;
      last_reg   <= 1'b1;
      edge_pulse <= 1'b0;
    end
    else
    begin
      meta_reg   <= din;
      sync_reg   <= meta_reg;
      last_reg   <= sync_reg;
      edge_pulse <= FALL ? (last_reg & ~sync_reg) : (~last_reg & sync_reg);
    end
  end

endmodule

// >>> verif/tsq_top_asserts.sv
// tsq_top_asserts - port-level checks of the sequencer's bus slave and lines
// assumes only the tsq_top ports and one clock domain
`timescale 1ns/1ns
module tsq_chk
(
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pready,
  input wire        pslverr,
  input wire [31:0] prdata,
  input wire        meas_start,
  input wire [5:0]  line_o,
  input wire [5:0]  line_oe_n,
  input wire [3:0]  line_cmd
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////////
  // bus answer: one-cycle ready, exactly one cycle after access starts
  property p_rdy_pulse; pready |=> !pready; endproperty
  property p_rdy_resp; psel && penable && !pready |=> pready; endproperty
  property p_err_rdy; pslverr |-> pready; endproperty
  property p_rd_zero; !pready |-> prdata == 32'h0; endproperty
  // a pass needs a measurement answer and a source step between starts
  property p_ms_gap; meas_start |=> !meas_start [*2]; endproperty
  property p_cmd_pulse; |line_cmd |=> line_cmd == 4'h0; endproperty
  // every line floats high at the first edge after reset
  property p_rst_lines; $rose(presetn) |-> line_oe_n == 6'h3f && line_cmd == 4'h0; endproperty
  // the done pulse is far longer than a few cycles
  property p_mdone_low; $fell(line_o[1]) && !line_oe_n[1] |=> !line_o[1] [*8]; endproperty
  a_rdy_pulse: assert property (p_rdy_pulse) else $error("ready held");
  a_rdy_resp: assert property (p_rdy_resp) else $error("ready late");
  a_err_rdy: assert property (p_err_rdy) else $error("error without ready");
  a_rd_zero: assert property (p_rd_zero) else $error("read data outside answer");
  a_ms_gap: assert property (p_ms_gap) else $error("measure starts too close");
  a_cmd_pulse: assert property (p_cmd_pulse) else $error("command pulse held");
  a_rst_lines: assert property (p_rst_lines) else $error("lines not released");
  a_mdone_low: assert property (p_mdone_low) else $error("done pulse short");
  c_meas: cover property (meas_start);
  c_err: cover property (pready && pslverr);
  c_cmd: cover property (|line_cmd);
endmodule
bind tsq_top tsq_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .prdata(prdata), .meas_start(meas_start),
  .line_o(line_o), .line_oe_n(line_oe_n), .line_cmd(line_cmd));

// >>> verif/tsq_far.sv
// tsq_far - outside circuits on the six lines and the measurement engine
// assumes the bench sets the outside levels of floating lines
`timescale 1ns/1ns
module tsq_far
#(
  parameter LAT = 3
)
(
  input  wire       pclk,
  input  wire       presetn,
  input  wire [5:0] line_o,
  input  wire [5:0] line_oe_n,
  input  wire [5:0] ext_lvl,
  input  wire       meas_start,
  output reg        meas_done,
  output wire [5:0] line_i
);
  integer cnt;
  // a driven line shows the device level, a floating one the outside level
  assign line_i = (~line_oe_n & line_o) | (line_oe_n & ext_lvl);
  // conversion takes a fixed time, so the sequencer must wait for it
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt       <= 0;
      meas_done <= 1'b0;
    end
    else
    begin
      meas_done <= (cnt == 1);
      if (meas_start)
        cnt <= LAT;
      else if (cnt != 0)
        cnt <= cnt - 1;
    end
  end
endmodule

// >>> verif/testbench.sv
// testbench - bus-driven sequences for the trigger sequencer and its lines
// assumes tsq_top with a short settle step, tsq_far and the bound checker
`timescale 1ns/1ns
`include "tsq_consts.vh"
`define CHK(a, b) begin checks = checks + 1; if ((a) !== (b)) begin bad_count = bad_count + 1; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module testbench;
  reg         pclk, presetn, psel, penable, pwrite, trig_key, fault_event, err;
  reg  [7:0]  paddr;
  reg  [31:0] pwdata, rd;
  reg  [5:0]  ext_lvl;
  reg  [6:0]  ev_lvl;
  wire [15:0] level_out;
  wire [31:0] prdata;
  wire        pready, pslverr, meas_done, meas_start;
  wire [5:0]  line_i, line_o, line_oe_n;
  wire [3:0]  line_cmd;
  integer     bad_count, checks, n_meas, lowc, last_low, i, k, w, ramp;
  tsq_top #(.STEP_CYC(4)) uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .line_i(line_i), .line_o(line_o), .line_oe_n(line_oe_n),
    .trig_key(trig_key), .fault_event(fault_event), .event_level(ev_lvl), .meas_done(meas_done),
    .meas_start(meas_start), .level_out(level_out), .line_cmd(line_cmd));
  tsq_far u_far (.pclk(pclk), .presetn(presetn), .line_o(line_o), .line_oe_n(line_oe_n),
    .ext_lvl(ext_lvl), .meas_start(meas_start), .meas_done(meas_done), .line_i(line_i));
  always #4 pclk = ~pclk;
  // count passes and the width of each done pulse on line 2
  always @(posedge pclk)
  begin
    if (level_out === 16'h0003)
      ramp = 1;
    if (meas_start === 1'b1)
      n_meas = n_meas + 1;
    if (line_oe_n[1] === 1'b0 && line_o[1] === 1'b0)
      lowc = lowc + 1;
    else if (lowc != 0)
    begin
      last_low = lowc;
      lowc = 0;
    end
  end
  ////////////////////////////////////////////////////////////////
  task test_done;
  begin
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  end
  endtask
  // one apb transfer; request held until pready is seen at a rising edge, answer taken there
  task apb(input reg wr, input reg [7:0] a, input reg [31:0] d);
  begin
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    for (w = 0; w < 20 && pready !== 1'b1; w = w + 1)
      @(posedge pclk);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (w == 20)
    begin
      bad_count = bad_count + 1;
      test_done;
    end
  end
  endtask
  task wr(input reg [7:0] a, input reg [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rdx(input reg [7:0] a, input reg [31:0] e, input reg ee);
  begin
    apb(1'b0, a, 32'h0);
    `CHK(rd, e)
    `CHK(err, ee)
  end
  endtask
  task cfg(input reg [2:0] n, input reg [2:0] fn, input reg [2:0] act, input reg ee);
  begin
    apb(1'b1, `TSQ_OFS_LINE0 + {3'h0, n - 3'h1, 2'h0}, {21'h0, act, 1'b0, fn, 4'h0});
    `CHK(err, ee)
  end
  endtask
  task waitm(input integer t);
  begin
    for (w = 0; w < 5000 && n_meas < t; w = w + 1)
      @(posedge pclk);
    `CHK(n_meas, t)
  end
  endtask
  // one arm event from the given source, none taken before it fires
  task ev_run(input reg [1:0] src);
  begin
    wr(`TSQ_OFS_ARM, {16'h1, 14'h0, src});
    k = n_meas;
    wr(`TSQ_OFS_CMD, 32'h1);
    repeat (50) @(posedge pclk);
    `CHK(n_meas, k)
    if (src == `TSQ_SRC_BUS)
      wr(`TSQ_OFS_CMD, 32'h2);
    ext_lvl[0] <= (src != `TSQ_SRC_EXT);
    trig_key   <= (src == `TSQ_SRC_MAN);
    repeat (510) @(posedge pclk);
    ext_lvl[0] <= 1'b1;
    trig_key   <= 1'b0;
    waitm(k + 1);
  end
  endtask
  ////////////////////////////////////////////////////////////////
  initial
  begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    trig_key = 0; fault_event = 0; ext_lvl = 6'h3f; bad_count = 0; checks = 0;
    ev_lvl = 7'h00; ramp = 0;
    n_meas = 0; lowc = 0; last_low = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rdx(`TSQ_OFS_ARM, 32'h00010000, 1'b0);
    rdx(`TSQ_OFS_STATUS, 32'h1, 1'b0);
    rdx(8'h40, 32'h0, 1'b1);
    `CHK(n_meas, 0)
    wr(`TSQ_OFS_DELAY, 32'h2);
    wr(`TSQ_OFS_ARM, 32'h00020000);
    wr(`TSQ_OFS_TRIG, 32'h00030000);
    cfg(2, `TSQ_FN_MDONE, 0, 1'b0);
    wr(`TSQ_OFS_CMD, 32'h1);
    waitm(6);
    repeat (2700) @(posedge pclk);
    `CHK(n_meas, 6)
    `CHK(last_low >= 1250 && last_low <= 3750, 1'b1)
    apb(1'b0, `TSQ_OFS_STATUS, 32'h0);
    `CHK(rd[5:0], 6'h01)
    // slewed source ramps 0, 3, 6, 9 then settles on 10
    wr(`TSQ_OFS_LEVEL, 32'h0003000a);
    wr(`TSQ_OFS_CTRL, 32'hc);
    wr(`TSQ_OFS_CMD, 32'h1);
    waitm(20);
    `CHK(ramp, 1)
    `CHK(level_out, 16'h000a)
    wr(`TSQ_OFS_CMD, 32'h4);
    wr(`TSQ_OFS_CTRL, 32'h0);
    k = n_meas;
    repeat (100) @(posedge pclk);
    `CHK(n_meas, k)
    // manual input reads back, other functions refuse the read
    cfg(4, `TSQ_FN_MIN, 0, 1'b0);
    rdx(`TSQ_OFS_LINE0 + 8'h0c, 32'h1, 1'b0);
    ext_lvl[3] <= 1'b0;
    repeat (5) @(posedge pclk);
    rdx(`TSQ_OFS_LINE0 + 8'h0c, 32'h0, 1'b0);
    cfg(4, `TSQ_FN_MOUTH, 0, 1'b0);
    rdx(`TSQ_OFS_LINE0 + 8'h0c, 32'h0, 1'b1);
    rdx(`TSQ_OFS_ERR, {16'h0, `TSQ_ERR_NOT_INPUT}, 1'b0);
    cfg(4, `TSQ_FN_DOUT, 0, 1'b1);
    rdx(`TSQ_OFS_ERR, {16'h0, `TSQ_ERR_BAD_CFG}, 1'b0);
    `CHK(({line_oe_n[3], line_o[3]}), 2'b01)
    // every action in both battery modes, outputs and inputs
    for (k = 1; k < 3; k = k + 1)
    begin
      wr(`TSQ_OFS_CTRL, k);
      cfg(1, `TSQ_FN_MDONE, 0, 1'b1);
      cfg(3, `TSQ_FN_TRIGIN, 0, 1'b1);
      for (i = 0; i < 7; i = i + 1)
      begin
        cfg(5, `TSQ_FN_DOUT, i[2:0], (k == 1) ? (i > 4) : (i == 3 || i == 4));
        cfg(5, `TSQ_FN_DIN, i[2:0], (k == 1) ? (i > 3) : (i > 1));
      end
    end
    wr(`TSQ_OFS_CTRL, 32'h1);
    cfg(6, `TSQ_FN_DIN, `TSQ_ACT_SSTART, 1'b0);
    ext_lvl[5] <= 1'b0;
    for (w = 0; w < 20 && line_cmd !== 4'h4; w = w + 1)
      @(negedge pclk);
    `CHK(line_cmd, 4'h4)
    // event output follows its own event level
    cfg(5, `TSQ_FN_DOUT, `TSQ_ACT_OVERV, 1'b0);
    ev_lvl <= 7'h02;
    repeat (3) @(posedge pclk);
    `CHK(({line_oe_n[4], line_o[4]}), 2'b01)
    wr(`TSQ_OFS_CTRL, 32'h0);
    cfg(5, `TSQ_FN_DOUT, 0, 1'b1);
    // external source takes line 1 away from manual input
    cfg(1, `TSQ_FN_MIN, 0, 1'b0);
    wr(`TSQ_OFS_TRIG, 32'h00010001);
    rdx(`TSQ_OFS_TRIG, 32'h00010000, 1'b0);
    ev_run(`TSQ_SRC_BUS);
    ev_run(`TSQ_SRC_EXT);
    rdx(`TSQ_OFS_LINE0, 32'h0, 1'b1);
    ev_run(`TSQ_SRC_MAN);
    cfg(3, `TSQ_FN_FAULT, 0, 1'b0);
    fault_event <= 1'b1;
    @(posedge pclk);
    fault_event <= 1'b0;
    repeat (3) @(posedge pclk);
    `CHK(line_o[2], 1'b0)
    wr(`TSQ_OFS_CMD, 32'h8);
    repeat (3) @(posedge pclk);
    `CHK(line_o[2], 1'b1)
    test_done;
  end
endmodule
